// ### mfs_chk.sv
/* Assertions on the multifunction switch ports.
   Assumes a bind to mfs_switch with its DIV handed on. */
`timescale 1ns/1ps
`default_nettype none
module mfs_chk
   import mfs_pkg::*;
#(
   parameter int unsigned DIV = 4
)
(
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire logic                       trg_i,
   input wire logic [mfs_pkg::TIME_W-1:0] hold_time_i,
   input wire logic [mfs_pkg::TIME_W-1:0] press_time_i,
   input wire logic                       q_o,
   input wire logic                       cont_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] hc;
   // Clocks spent high, so that expiry can be tied to whole program cycles.
   always_ff @(posedge clk_i) hc <= (rst_i || !q_o) ? 32'h0000_0000 : hc + 32'h0000_0001;
   property p_rst; $fell(rst_i) |-> !q_o && !cont_o; endproperty
   a_rst: assert property (p_rst) else $error("output on after reset");
   property p_cq; cont_o |-> q_o; endproperty
   a_cq: assert property (p_cq) else $error("continuous without output");
   property p_on; $rose(q_o) |-> $past(trg_i) && !cont_o; endproperty
   a_on: assert property (p_on) else $error("output rose without trigger");
   property p_ct; $rose(cont_o) |-> hc == press_time_i * DIV && $past(trg_i); endproperty
   a_ct: assert property (p_ct) else $error("continuous at wrong time");
   property p_off; $fell(q_o) && !$past(rst_i) |-> hc == hold_time_i * DIV || $past(trg_i); endproperty
   a_off: assert property (p_off) else $error("output fell at wrong time");
   property p_cf; $fell(cont_o) && !$past(rst_i) |-> !q_o && $past(trg_i); endproperty
   a_cf: assert property (p_cf) else $error("continuous ended wrongly");
   // The hold of three clocks matches the divider of four used in simulation.
   property p_gap; $changed(q_o) |=> $stable(q_o) [*3]; endproperty
   a_gap: assert property (p_gap) else $error("output moved between ticks");
endmodule  // mfs_chk
`default_nettype wire

// ### mfs_pkg.sv
/*
 Package for the multifunction light switch: timing constants and the state enumeration.
 Assumes a 20 MHz system clock and a 10 ms program cycle produced by a divider.
*/
package mfs_pkg;

   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned CYCLE_US        = 10_000;
   localparam int unsigned CYCLE_CLKS      = CLK_HZ / 1_000_000 * CYCLE_US;
   localparam int unsigned TIME_W          = 16;
   localparam int unsigned DIV_W           = 18;
   // Defaults in program cycles of 10 ms.
   localparam logic [15:0] HOLD_DEFAULT    = 16'h03E8;
   localparam logic [15:0] PRESS_DEFAULT   = 16'h0064;
   localparam logic [15:0] TIME_RESET      = 16'h0000;

   typedef enum logic [1:0] {
      MFS_OFF,
      MFS_TIMED,
      MFS_CONT
   } mfs_state_t;

endpackage : mfs_pkg

// ### mfs_switch.sv
/*
 Multifunction light switch: pulse switch with off-delay, or continuous
 lighting after a long press; a further actuation turns the output off.
 Assumes the trigger is synchronous to clk_i and that rst_i is raised on power loss.
*/
// Operation
// R1: Rising trigger sets output, restarts elapsed time.
// R2: Elapsed reaching hold time clears output.
// R3: Power loss clears elapsed time.
// R4: Long press enables continuous lighting.
// R5: Further actuation while active turns output off.
// R6: Both times at least 0.10 s; the code sets no lower limit on hold_time_i or press_time_i.
// R7: Sample once per cycle, whole-cycle steps.
`timescale 1ns/1ps
`default_nettype none
module mfs_switch
   import mfs_pkg::*;
#(
   parameter int unsigned DIV = CYCLE_CLKS
)
(
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      trg_i,
   input  wire logic [mfs_pkg::TIME_W-1:0] hold_time_i,
   input  wire logic [mfs_pkg::TIME_W-1:0] press_time_i,
   output logic                           q_o,
   output logic                           cont_o
);
   import mfs_pkg::*;

   typedef struct packed {
      mfs_state_t        st;
      logic              trg_q;
      logic              pressing;
      logic [TIME_W-1:0] elapsed;
      logic [TIME_W-1:0] press;
      logic              q;
   } mfs_st_t;

   mfs_st_t s;
   mfs_st_t next_s;
   logic    tick;
   logic    rise;

   mfs_tick #(
      .DIV (DIV)
   ) u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (tick)
   );

   // Trigger is looked at only on the program cycle tick, like a scanned program.
   assign rise = tick && trg_i && !s.trg_q; // R7

   always_comb
   begin
      next_s = s;
      if (tick)
      begin
         next_s.trg_q = trg_i; // R7
         if (!trg_i)
            next_s.pressing = 1'b0;
         else if (s.pressing && s.press != '1)
            next_s.press = s.press + 1'b1; // R7
         unique case (s.st)
            MFS_OFF:
            begin
               if (rise)
               begin
                  next_s.st       = MFS_TIMED; // R1
                  next_s.q        = 1'b1; // R1
                  next_s.elapsed  = TIME_RESET; // R1
                  next_s.pressing = 1'b1;
                  next_s.press    = TIME_RESET;
               end
            end
            MFS_TIMED:
            begin
               if (rise)
               begin
                  next_s.st       = MFS_OFF; // R5
                  next_s.q        = 1'b0; // R5
                  next_s.elapsed  = TIME_RESET; // R5
                  next_s.pressing = 1'b0;
               end
               else if (s.pressing && trg_i && s.press + 1'b1 >= press_time_i)
               begin
                  next_s.st       = MFS_CONT; // R4
                  next_s.pressing = 1'b0;
               end
               else if (s.elapsed + 1'b1 >= hold_time_i)
               begin
                  // A still-held trigger past the hold time does not extend lighting.
                  next_s.st      = MFS_OFF; // R2
                  next_s.q       = 1'b0; // R2
                  next_s.elapsed = TIME_RESET;
               end
               else
               begin
                  next_s.elapsed = s.elapsed + 1'b1; // R7
               end
            end
            MFS_CONT:
            begin
               if (rise)
               begin
                  next_s.st      = MFS_OFF; // R5
                  next_s.q       = 1'b0; // R5
                  next_s.elapsed = TIME_RESET; // R5
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s         <= '0; // R3
         s.st      <= MFS_OFF;
         s.elapsed <= TIME_RESET; // R3
      end
      else
      begin
         s <= next_s;
      end
   end

   assign q_o    = s.q;
   assign cont_o = (s.st == MFS_CONT);
endmodule // mfs_switch
`default_nettype wire

// ### mfs_tick.sv
/*
 Program cycle divider: one-cycle enable pulse every DIV clocks.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mfs_tick
   import mfs_pkg::*;
#(
   parameter int unsigned DIV = CYCLE_CLKS
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } mfs_tick_st_t;

   mfs_tick_st_t s;
   mfs_tick_st_t next_s;

   always_comb
   begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (s.cnt == DIV_W'(DIV - 1))
      begin
         next_s.cnt  = '0;
         next_s.tick = 1'b1;
      end
      else
      begin
         next_s.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick_o = s.tick;
endmodule // mfs_tick
`default_nettype wire

// ### mfs_trg_model.sv
/* User program logic that drives the trigger.
   Assumes press is called just after a falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module mfs_trg_model
(
   input  wire logic clk_i,
   output logic      trg_o
);
   initial trg_o = 1'b0;
   // Levels move only at falling edges, so the switch never samples a moving trigger.
   task automatic press(int hi, int lo);
      trg_o = 1'b1;
      repeat (hi) @(negedge clk_i);
      trg_o = 1'b0;
      repeat (lo) @(negedge clk_i);
   endtask
endmodule  // mfs_trg_model
`default_nettype wire

// ### tb_multifunction_light_switch.sv
/* Random presses checked each clock against a tick-level model.
   Assumes mfs_switch, mfs_chk and mfs_trg_model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb_multifunction_light_switch;
   import mfs_pkg::*;
   localparam int DV = 4;
   logic              clk_i = 1'b0, rst_i = 1'b1, trg_i, q_o, cont_o;
   // Both times stay at or above 0.10 s, i.e. ten program cycles of 10 ms.
   logic [TIME_W-1:0] hold = 16'h000C, press = 16'h000A;
   int                cnt, el, err_count, n_tests, seed = 22542;
   bit                prev, on, ct, held, eq, ec;
   always #25 clk_i = ~clk_i;
   // The divider wraps DV edges after release and its tick is seen one edge later.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt = -1;
         {el, prev, on, ct} = 0;
      end
      else if (++cnt > 0 && cnt % DV == 0)
      begin
         if (on && trg_i && !prev) {on, ct} = 2'h0;
         else if (!on) {on, el, held} = {trg_i && !prev, 32'h0000_0000, 1'b1};
         else if (!ct)
         begin
            held = held && trg_i;
            if (held && el + 1 >= press) ct = 1'b1;
            else if (el + 1 >= hold) on = 1'b0;
            else el++;
         end
         prev = trg_i;
      end
      eq = on;
      ec = ct;
   end
   task automatic check(logic got, logic exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %b, model %b", $time, got, exp);
      end
   endtask
   always @(negedge clk_i)
      if (!rst_i)
      begin
         check(q_o, eq);
         check(cont_o, ec);
      end
   task automatic results;
      $display("mismatches %0d of %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (2)
      begin
         repeat (2) @(negedge clk_i);
         rst_i = 1'b0;
         repeat (60) i_mfs_trg_model.press($unsigned($random(seed)) % 60 + 1, $unsigned($random(seed)) % 30 + 1);
         // Leaves the output on so that the reset below lands mid-run.
         i_mfs_trg_model.press(9, 2);
         rst_i = 1'b1;
      end
      results();
   end
   mfs_switch #(.DIV(DV)) i_mfs_switch (.clk_i(clk_i), .rst_i(rst_i), .trg_i(trg_i), .hold_time_i(hold),
      .press_time_i(press), .q_o(q_o), .cont_o(cont_o));
   mfs_trg_model i_mfs_trg_model (.clk_i(clk_i), .trg_o(trg_i));
endmodule  // tb_multifunction_light_switch
bind mfs_switch mfs_chk #(.DIV(DIV)) i_mfs_chk (.*);
`default_nettype wire
